//--- rtl/axis_pkg.sv
// Purpose: Shared constants and carrier types of the single-axis positioning controller.
// Assumes: APB register map with 32-bit aligned words; 125 MHz core clock.
// Notes: Functional notes follow.
//
// Functional notes
// - Motion and synchronization work only while enable is 1; position counting goes on regardless.
// - Target position is a full-range signed 32-bit value.
// - Position counter has no limit check and wraps at both ends.
// - Home value is a signed 32-bit point loaded only on synchronization.
// - Stop lead distance is an unsigned 16-bit gap before the target.
// - Converter speed output is full scale times (256 - code) / 256.
// - Contactor drive: code zero drives rapid only, else creep only.
// - Jog is started and run by jog selects together with move trigger.
// - A positioning move starts on a rising edge of move trigger.
// - Rising edge of software home trigger loads home value as position.
// - Hardware home arm selects and enables home switch synchronization.
// - ok flag is 1 after error-free execution, else 0.
// - Current position is shown continuously as a signed 32-bit value.
// - motion idle is 0 while moving; new moves accepted only when 1.
// - Move ends at the switch-off point or on abort, then idle is set.
// - home switch seen is set when hardware synchronization happens.
// - Without synchronization, positioning is refused and only jog runs.
// - Software sync needs idle at the edge and then sets position synced.
// - Hardware sync needs arm, switch rise and matching direction at next pulse.
// - Contactor drive uses creep, rapid, backward and forward outputs.
package axis_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_TARGET = 8'h04;
   localparam logic [7:0] OFS_HOME   = 8'h08;
   localparam logic [7:0] OFS_LEAD   = 8'h0C;
   localparam logic [7:0] OFS_SPEED  = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_POS    = 8'h18;

   // Analog full scale in output steps and largest legal code.
   localparam logic [8:0] SPEED_FULL = 9'h100;
   localparam logic [7:0] CODE_MAX   = 8'hFE;

   // Values after reset.
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // Control bits written by software.
   typedef struct packed {
      logic home_dir_fwd;
      logic contactor;
      logic sw_home_trigger;
      logic move_trigger;
      logic jog_select_b;
      logic jog_select_a;
      logic hw_home_arm;
      logic enable;
   } ctrl_type;

   // Status bits read by software.
   typedef struct packed {
      logic [1:0] state;
      logic       position_synced;
      logic       home_switch_seen;
      logic       motion_idle;
      logic       ok_flag;
   } status_type;

   // Drive lines towards converter or contactors.
   typedef struct packed {
      logic [8:0] speed_level;
      logic       creep;
      logic       rapid;
      logic       backward;
      logic       forward;
   } drive_type;

   // Motion states, binary coded.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_POS  = 2'b01,
      ST_JOG  = 2'b10
   } state_type;

endpackage : axis_pkg

//--- rtl/pin_sync.sv
// Purpose: Two-stage synchroniser for a group of pin inputs.
// Assumes: Pins are asynchronous to core_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 3
) (
   // Clock, reset and enable.
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Pins in, synchronised levels out.
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] meta_r;

   // One two-flop chain per pin.
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      always_ff @(posedge core_clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            meta_r[i]    <= 1'b0;
            level_out[i] <= 1'b0;
         end
         else if (ce)
         begin
            meta_r[i]    <= pin_in[i];
            level_out[i] <= meta_r[i];
         end
      end
   end

endmodule : pin_sync

//--- rtl/rise_detect.sv
// Purpose: Rising edge detection against the previous sampled value.
// Assumes: Inputs are already on core_clk.
// Notes: Sampling happens only on cycles where sample_en is high.
`timescale 1ns/100ps
module rise_detect #(
   parameter int WIDTH = 2
) (
   // Clock, reset and enable.
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Sampling control and levels.
   input  wire logic             sample_en,
   input  wire logic [WIDTH-1:0] level_in,
   output logic      [WIDTH-1:0] rise_out
);

   logic [WIDTH-1:0] prev_r;
   logic [WIDTH-1:0] prev_nxt;

   // Take the new value while sampling; keep the previous value otherwise.
   always_comb
   begin
      prev_nxt = sample_en ? level_in : prev_r;
      rise_out = sample_en ? (level_in & ~prev_r) : '0;
   end

   // Register the sampled value.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_r <= '0;
      else if (ce)
         prev_r <= prev_nxt;
   end

endmodule : rise_detect

//--- rtl/axis_positioning_control.sv
// Purpose: Single-axis positioning controller with APB registers.
// Assumes: Count pulse, count direction and home switch are async pins.
// Notes: Drive outputs serve a frequency converter or a contactor circuit.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/100ps
module axis_positioning_control (
   // Clock, reset and clock enable.
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Encoder and home switch pins.
   input  wire logic        count_pulse,
   input  wire logic        count_dir_fwd,
   input  wire logic        home_switch,
   // Drive outputs.
   output logic      [8:0]  speed_level,
   output logic             creep_out,
   output logic             rapid_out,
   output logic             backward_out,
   output logic             forward_out
);

   axis_pkg::ctrl_type   ctrl_r;
   axis_pkg::ctrl_type   ctrl_nxt;
   axis_pkg::state_type  state_r;
   axis_pkg::state_type  state_nxt;
   axis_pkg::drive_type  drv_r;
   axis_pkg::drive_type  drv_nxt;
   logic signed [31:0]   target_r;
   logic signed [31:0]   target_nxt;
   logic signed [31:0]   home_r;
   logic signed [31:0]   home_nxt;
   logic [15:0]          lead_r;
   logic [15:0]          lead_nxt;
   logic [7:0]           code_r;
   logic [7:0]           code_nxt;
   logic signed [31:0]   pos_r;
   logic signed [31:0]   pos_nxt;
   logic                 synced_r;
   logic                 synced_nxt;
   logic                 seen_r;
   logic                 seen_nxt;
   logic                 err_r;
   logic                 err_nxt;
   logic                 fwd_r;
   logic                 fwd_nxt;
   logic                 pend_r;
   logic                 pend_nxt;
   logic [31:0]          rdata_r;
   logic [31:0]          rdata_nxt;
   logic [2:0]           pin_lvl;
   logic [2:0]           pin_rise;
   logic [2:0]           trig_rise;
   logic                 run;
   logic                 wr_en;
   logic                 addr_ok;
   logic                 jog_any;
   logic signed [31:0]   rem;
   logic                 at_stop;
   logic                 pulse;
   axis_pkg::status_type status;

   // Bus and execution qualifiers.
   assign run     = ctrl_r.enable;
   assign wr_en   = psel && penable && pwrite;
   assign pulse   = pin_rise[0];
   assign jog_any = ctrl_r.jog_select_a || ctrl_r.jog_select_b;

   // Pin synchronisers: pulse, direction, home switch.
   pin_sync #(
      .WIDTH (3)
   ) u_pins (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .pin_in    ({home_switch, count_dir_fwd, count_pulse}),
      .level_out (pin_lvl)
   );

   // Pin edges are watched on every cycle.
   rise_detect #(
      .WIDTH (3)
   ) u_pin_edges (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .sample_en (1'b1),
      .level_in  ({pin_lvl[2], 1'b0, pin_lvl[0]}),
      .rise_out  (pin_rise)
   );

   // Trigger edges are sampled only while executing.
   rise_detect #(
      .WIDTH (3)
   ) u_trig_edges (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .sample_en (run),
      .level_in  ({ctrl_r.hw_home_arm, ctrl_r.sw_home_trigger,
                   ctrl_r.move_trigger}),
      .rise_out  (trig_rise)
   );

   // Remaining distance in the direction of travel.
   always_comb
   begin
      rem     = fwd_r ? (target_r - pos_r) : (pos_r - target_r);
      at_stop = rem <= $signed({16'h0000, lead_r});
   end

   // Address decode for the register map.
   always_comb
   begin
      case (paddr)
         axis_pkg::OFS_CTRL, axis_pkg::OFS_TARGET, axis_pkg::OFS_HOME, axis_pkg::OFS_LEAD,
         axis_pkg::OFS_SPEED, axis_pkg::OFS_STATUS, axis_pkg::OFS_POS:   addr_ok = 1'b1;
         default:             addr_ok = 1'b0;
      endcase
   end

   // Status word seen by software.
   always_comb
   begin
      status.state            = state_r;
      status.position_synced  = synced_r;
      status.home_switch_seen = seen_r;
      status.motion_idle      = (state_r == axis_pkg::ST_IDLE);
      status.ok_flag          = run && !err_r;
   end

   // Register writes in the access phase, read data capture in the setup phase.
   always_comb
   begin
      ctrl_nxt   = ctrl_r;
      target_nxt = target_r;
      home_nxt   = home_r;
      lead_nxt   = lead_r;
      code_nxt   = code_r;
      rdata_nxt  = rdata_r;
      if (wr_en)
      begin
         case (paddr)
            axis_pkg::OFS_CTRL:   ctrl_nxt = pwdata[7:0];
            axis_pkg::OFS_TARGET: target_nxt = pwdata;
            axis_pkg::OFS_HOME:   home_nxt = pwdata;
            axis_pkg::OFS_LEAD:   lead_nxt = pwdata[15:0];
            axis_pkg::OFS_SPEED:  code_nxt = pwdata[7:0];
            default:              ctrl_nxt = ctrl_r;
         endcase
      end
      if (psel && !penable)
      begin
         case (paddr)
            axis_pkg::OFS_CTRL:   rdata_nxt = {24'h00_0000, ctrl_r};
            axis_pkg::OFS_TARGET: rdata_nxt = target_r;
            axis_pkg::OFS_HOME:   rdata_nxt = home_r;
            axis_pkg::OFS_LEAD:   rdata_nxt = {16'h0000, lead_r};
            axis_pkg::OFS_SPEED:  rdata_nxt = {24'h00_0000, code_r};
            axis_pkg::OFS_STATUS: rdata_nxt = {26'h000_0000, status};
            axis_pkg::OFS_POS:    rdata_nxt = pos_r;
            default:              rdata_nxt = axis_pkg::RST_WORD;
         endcase
      end
   end

   // APB answer: zero wait states, error on unmapped address.
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata  = rdata_r;

   // Register file flops.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r   <= '0;
         target_r <= axis_pkg::RST_WORD;
         home_r   <= axis_pkg::RST_WORD;
         lead_r   <= 16'h0000;
         code_r   <= 8'h00;
         rdata_r  <= axis_pkg::RST_WORD;
      end
      else if (ce)
      begin
         ctrl_r   <= ctrl_nxt;
         target_r <= target_nxt;
         home_r   <= home_nxt;
         lead_r   <= lead_nxt;
         code_r   <= code_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // Motion, position and synchronization next state.
   always_comb
   begin
      state_nxt  = state_r;
      pos_nxt    = pos_r;
      synced_nxt = synced_r;
      seen_nxt   = seen_r;
      err_nxt    = err_r;
      fwd_nxt    = fwd_r;
      pend_nxt   = pend_r;
      // Counting wraps freely at both ends.
      if (pulse)
         pos_nxt = pin_lvl[1] ? pos_r + 32'sd1 : pos_r - 32'sd1;
      // Arming clears the seen flag and any old pending edge.
      if (trig_rise[2])
      begin
         seen_nxt = 1'b0;
         pend_nxt = 1'b0;
      end
      if (!ctrl_r.hw_home_arm || !run)
         pend_nxt = 1'b0;
      else if (pin_rise[2])
         pend_nxt = 1'b1;
      // Direction check at the next counting pulse.
      if (pend_r && pulse && run && ctrl_r.hw_home_arm)
      begin
         pend_nxt = 1'b0;
         if (pin_lvl[1] == ctrl_r.home_dir_fwd)
         begin
            pos_nxt    = home_r;
            synced_nxt = 1'b1;
            seen_nxt   = 1'b1;
         end
      end
      case (state_r)
         axis_pkg::ST_IDLE:
         begin
            if (!run)
               state_nxt = axis_pkg::ST_IDLE;
            else if (trig_rise[1])
            begin
               pos_nxt    = home_r;
               synced_nxt = 1'b1;
            end
            else if (jog_any && ctrl_r.move_trigger)
            begin
               state_nxt = axis_pkg::ST_JOG;
               fwd_nxt   = ctrl_r.jog_select_b;
               err_nxt   = (code_r > axis_pkg::CODE_MAX);
            end
            else if (trig_rise[0] && !jog_any)
            begin
               if (!synced_r || code_r > axis_pkg::CODE_MAX)
                  err_nxt = 1'b1;
               else
               begin
                  state_nxt = axis_pkg::ST_POS;
                  fwd_nxt   = target_r > pos_r;
                  err_nxt   = 1'b0;
               end
            end
         end
         axis_pkg::ST_POS:
         begin
            if (!run || at_stop)
               state_nxt = axis_pkg::ST_IDLE;
         end
         axis_pkg::ST_JOG:
         begin
            if (!run || !ctrl_r.move_trigger || !jog_any)
               state_nxt = axis_pkg::ST_IDLE;
         end
         default: state_nxt = axis_pkg::ST_IDLE;
      endcase
   end

   // Drive lines follow the next motion state.
   always_comb
   begin
      drv_nxt = '0;
      if (state_nxt != axis_pkg::ST_IDLE)
      begin
         drv_nxt.forward  = fwd_nxt;
         drv_nxt.backward = !fwd_nxt;
         if (ctrl_r.contactor)
         begin
            drv_nxt.rapid = (code_r == 8'h00);
            drv_nxt.creep = (code_r != 8'h00);
         end
         else
            drv_nxt.speed_level = axis_pkg::SPEED_FULL - {1'b0, code_r};
      end
   end

   // Motion flops.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r  <= axis_pkg::ST_IDLE;
         pos_r    <= axis_pkg::RST_WORD;
         synced_r <= 1'b0;
         seen_r   <= 1'b0;
         err_r    <= 1'b0;
         fwd_r    <= 1'b0;
         pend_r   <= 1'b0;
         drv_r    <= '0;
      end
      else if (ce)
      begin
         state_r  <= state_nxt;
         pos_r    <= pos_nxt;
         synced_r <= synced_nxt;
         seen_r   <= seen_nxt;
         err_r    <= err_nxt;
         fwd_r    <= fwd_nxt;
         pend_r   <= pend_nxt;
         drv_r    <= drv_nxt;
      end
   end

   // Drive pins come straight from flops.
   assign speed_level  = drv_r.speed_level;
   assign creep_out    = drv_r.creep;
   assign rapid_out    = drv_r.rapid;
   assign backward_out = drv_r.backward;
   assign forward_out  = drv_r.forward;

   // Checks on the motion logic.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_off_goes_idle: assert property (
      ce && !run |=> state_r == axis_pkg::ST_IDLE)
      else $error("Motion continued while disabled.");
   a_start_needs_sync: assert property (
      ce && state_r == axis_pkg::ST_IDLE && state_nxt == axis_pkg::ST_POS
      |-> synced_r && run)
      else $error("Positioning started without synchronization.");
   a_sw_sync_load: assert property (
      ce && run && trig_rise[1] && state_r == axis_pkg::ST_IDLE && !pulse
      |=> pos_r == $past(home_r) && synced_r)
      else $error("Software sync did not load home value.");
   a_idle_no_drive: assert property (
      state_r == axis_pkg::ST_IDLE |-> drv_r == '0)
      else $error("Drive active while idle.");
   a_speed_scale: assert property (
      ce && state_nxt != axis_pkg::ST_IDLE && !ctrl_r.contactor
      |=> speed_level == 9'h100 - {1'b0, $past(code_r)})
      else $error("Speed level does not match code.");
   a_rapid_code_zero: assert property (
      rapid_out |-> !creep_out && $past(code_r) == 8'h00)
      else $error("Rapid traverse with nonzero code.");
   a_ok_on_refuse: assert property (
      ce && run && state_r == axis_pkg::ST_IDLE && trig_rise[0] && !trig_rise[1] && !jog_any
      && !synced_r |=> !status.ok_flag)
      else $error("ok flag high after a refused start.");
   a_seen_sets_sync: assert property (
      ce && $rose(seen_r) |-> synced_r && $past(pend_r) && $past(pulse))
      else $error("Home seen without hardware sync.");
   a_stop_at_lead: assert property (
      ce && state_r == axis_pkg::ST_POS && at_stop
      |=> state_r == axis_pkg::ST_IDLE && !forward_out && !backward_out)
      else $error("Drive not switched off at lead distance.");

endmodule : axis_positioning_control

//--- tb/motor_model.sv
// Purpose: Behavioural motor and encoder that stand behind the drive lines.
// Assumes: One count pulse every 16 clocks while a direction line is on.
// Notes: The encoder lines stay still while the drive is off.
`timescale 1ns/100ps
module motor_model (
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Drive lines from the controller.
   input  wire logic forward_out,
   input  wire logic backward_out,
   // Encoder pins back to the controller.
   output logic      count_pulse,
   output logic      count_dir_fwd
);
   logic [3:0] phase_r;
   logic [3:0] phase_nxt;
   logic       run;

   // The shaft turns only while a direction line is on.
   assign run       = forward_out | backward_out;
   assign phase_nxt = run ? phase_r + 4'h1 : 4'h0;

   // Direction moves only while the pulse is low, so no count sees it change.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_r       <= 4'h0;
         count_pulse   <= 1'b0;
         count_dir_fwd <= 1'b1;
      end
      else
      begin
         phase_r     <= phase_nxt;
         count_pulse <= run & phase_r[3];
         if (!count_pulse && run)
            count_dir_fwd <= forward_out;
      end
   end
endmodule : motor_model

//--- tb/test_axis_positioning_control.sv
// Purpose: Self-checking bench of the positioning controller.
// Assumes: Zero-wait APB slave; motor model turns the encoder.
// Notes: Each scenario is a task that judges its own results.
`timescale 1ns/100ps
module test_axis_positioning_control;
   logic        core_clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        count_pulse;
   logic        count_dir_fwd;
   logic        home_switch;
   logic [8:0]  speed_level;
   logic        creep_out;
   logic        rapid_out;
   logic        backward_out;
   logic        forward_out;
   logic [31:0] rd_v;
   logic        err_v;
   int          error_cnt;
   int          checked;

   // Design and the motor behind it; the clock enable is tied on.
   axis_positioning_control u_axis_positioning_control (.core_clk(core_clk), .rst_n(rst_n),
      .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_pulse(count_pulse), .count_dir_fwd(count_dir_fwd), .home_switch(home_switch),
      .speed_level(speed_level), .creep_out(creep_out), .rapid_out(rapid_out),
      .backward_out(backward_out), .forward_out(forward_out));
   motor_model u_motor_model (.core_clk(core_clk), .rst_n(rst_n), .forward_out(forward_out),
      .backward_out(backward_out), .count_pulse(count_pulse), .count_dir_fwd(count_dir_fwd));

   // Clock of 8 ns.
   always #4 core_clk = ~core_clk;

   // Compares one value and counts the outcome.
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
      @(posedge core_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= adr;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1)
         @(posedge core_clk);
      rd_v = prdata;
      err_v = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
      apb(1'b1, adr, wd);
   endtask : wr

   // Polls a register until the masked value matches or the bound runs out.
   task automatic rdw(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, a, 32'h0000_0000);
         n++;
      end
      while ((rd_v & m) !== v && n < 2000);
      chk(nm, rd_v & m, v);
   endtask : rdw

   task automatic settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle

   task automatic t_reset;
      rdw("status", axis_pkg::OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0002);
      wr(axis_pkg::OFS_POS, 32'h1234_5678);
      rdw("position", axis_pkg::OFS_POS, 32'hFFFF_FFFF, 32'h0000_0000);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk("slverr", {31'h0000_0000, err_v}, 32'h0000_0001);
      chk("pready", {31'h0000_0000, pready}, 32'h0000_0001);
      $display("test reset done");
   endtask : t_reset

   task automatic t_refuse;
      wr(axis_pkg::OFS_SPEED, 32'h0000_0040);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0010);
      settle();
      chk("off drive", {30'h0000_0000, backward_out, forward_out}, 32'h0000_0000);
      rdw("off status", axis_pkg::OFS_STATUS, 32'h0000_0033, 32'h0000_0002);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0001);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0011);
      settle();
      chk("unsync drive", {30'h0000_0000, backward_out, forward_out}, 32'h0000_0000);
      rdw("unsync status", axis_pkg::OFS_STATUS, 32'h0000_0033, 32'h0000_0002);
      $display("test refuse done");
   endtask : t_refuse

   task automatic t_sync;
      wr(axis_pkg::OFS_HOME, 32'h0000_0010);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0001);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0021);
      rdw("sw home", axis_pkg::OFS_POS, 32'hFFFF_FFFF, 32'h0000_0010);
      rdw("synced", axis_pkg::OFS_STATUS, 32'h0000_003A, 32'h0000_000A);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0001);
      $display("test sync done");
   endtask : t_sync

   task automatic t_move(input logic [31:0] tgt, input logic [15:0] lead,
                         input logic [7:0] code, input logic fwd, input logic [31:0] fin);
      wr(axis_pkg::OFS_TARGET, tgt);
      wr(axis_pkg::OFS_LEAD, {16'h0000, lead});
      wr(axis_pkg::OFS_SPEED, {24'h00_0000, code});
      wr(axis_pkg::OFS_CTRL, 32'h0000_0011);
      settle();
      chk("speed", {23'h00_0000, speed_level}, {23'h00_0000, 9'h100 - code});
      chk("dir", {30'h0000_0000, backward_out, forward_out}, {30'h0000_0000, ~fwd, fwd});
      rdw("moving", axis_pkg::OFS_STATUS, 32'h0000_0033, 32'h0000_0011);
      rdw("done", axis_pkg::OFS_STATUS, 32'h0000_0033, 32'h0000_0003);
      rdw("end pos", axis_pkg::OFS_POS, 32'hFFFF_FFFF, fin);
      chk("stopped", {30'h0000_0000, backward_out, forward_out}, 32'h0000_0000);
      repeat (40) @(posedge core_clk);
      rdw("level", axis_pkg::OFS_STATUS, 32'h0000_0033, 32'h0000_0003);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0001);
      $display("test move done");
   endtask : t_move

   task automatic t_jog;
      wr(axis_pkg::OFS_HOME, 32'h7FFF_FFFE);
      wr(axis_pkg::OFS_SPEED, 32'h0000_0000);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0061);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0059);
      settle();
      chk("jog fwd", {28'h000_0000, creep_out, rapid_out, backward_out, forward_out},
          32'h0000_0005);
      rdw("jog state", axis_pkg::OFS_STATUS, 32'h0000_0032, 32'h0000_0020);
      rdw("wrap up", axis_pkg::OFS_POS, 32'hFFFF_FFFF, 32'h8000_0001);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0041);
      rdw("jog end", axis_pkg::OFS_STATUS, 32'h0000_0032, 32'h0000_0002);
      wr(axis_pkg::OFS_SPEED, 32'h0000_0005);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0055);
      settle();
      chk("jog bwd", {28'h000_0000, creep_out, rapid_out, backward_out, forward_out},
          32'h0000_000A);
      rdw("wrap down", axis_pkg::OFS_POS, 32'hFFFF_FFFF, 32'h7FFF_FFFF);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0041);
      $display("test jog done");
   endtask : t_jog

   task automatic t_hw;
      wr(axis_pkg::OFS_HOME, 32'h0000_0100);
      wr(axis_pkg::OFS_CTRL, 32'h0000_0083);
      wr(axis_pkg::OFS_CTRL, 32'h0000_009B);
      rdw("not seen", axis_pkg::OFS_STATUS, 32'h0000_0004, 32'h0000_0000);
      repeat (40) @(posedge core_clk);
      home_switch <= 1'b1;
      rdw("hw home", axis_pkg::OFS_POS, 32'hFFFF_FFFF, 32'h0000_0100);
      rdw("seen", axis_pkg::OFS_STATUS, 32'h0000_000C, 32'h0000_000C);
      home_switch <= 1'b0;
      wr(axis_pkg::OFS_CTRL, 32'h0000_0083);
      $display("test hw sync done");
   endtask : t_hw

   task automatic test_done;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // Main sequence.
   initial
   begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      home_switch = 1'b0;
      error_cnt = 0;
      checked = 0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_refuse();
      t_sync();
      t_move(32'h0000_0038, 16'h0005, 8'h40, 1'b1, 32'h0000_0033);
      t_move(32'hFFFF_FFF0, 16'h0000, 8'h00, 1'b0, 32'hFFFF_FFF0);
      t_jog();
      t_hw();
      test_done();
   end

   // Cuts a hang short after far more time than the scenarios need.
   initial
   begin
      #400000;
      error_cnt++;
      $display("[ERR] watchdog expired");
      test_done();
   end
endmodule : test_axis_positioning_control
